// ### common/ocpe_pkg.sv
package ocpe_pkg;

    localparam logic [7:0]  OFS_ROW_HI   = 8'h00;
    localparam logic [7:0]  OFS_ROW_MID  = 8'h04;
    localparam logic [7:0]  OFS_ROW_LO   = 8'h08;
    localparam logic [7:0]  OFS_ATTR_RD  = 8'h0c;
    localparam logic [7:0]  OFS_CTRL     = 8'h10;
    localparam logic [7:0]  OFS_PAL      = 8'h14;

    localparam int unsigned A_CTRL_B     = 15;
    localparam int unsigned A_UL2_B      = 9;
    localparam int unsigned A_UL1_B      = 8;
    localparam int unsigned A_SHIFT_B    = 7;
    localparam int unsigned A_TRANS_B    = 6;
    localparam int unsigned A_BLINK_B    = 5;
    localparam int unsigned A_ITAL_B     = 4;
    localparam int unsigned A_FRINGE_B   = 1;
    localparam int unsigned A_SMOOTH_B   = 0;

    localparam int unsigned C_UL2_B      = 15;
    localparam int unsigned C_UL1_B      = 14;
    localparam int unsigned C_BLINK_B    = 7;
    localparam int unsigned C_SIZE_SEL_B = 6;
    localparam int unsigned P_MODE_B     = 15;

    localparam logic [2:0]  COL_BLACK    = 3'h0;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [4:0]  PERIOD_CYC   = 5'h10;
    localparam logic [2:0]  STALL_START  = 3'h4;
    localparam logic [2:0]  STALL_LAST   = 3'h6;
    localparam logic [4:0]  SHIFT_PIX    = 5'h08;
    localparam int unsigned HIST_W       = 32;

    typedef struct packed {
        logic       active;
        logic       fg;
        logic       bg;
        logic       ul;
        logic [2:0] color;
    } ocpe_pix_t;

    typedef struct packed {
        logic [15:0]       cur_shift;
        logic [15:0]       adj_shift;
        logic [15:0]       disp_cur;
        logic [15:0]       disp_adj;
        logic [15:0]       attr;
        logic [2:0]        fg_old;
        logic [14:0]       merged;
        logic              last_ctrl;
        logic [15:0]       ctrl;
        logic [15:0]       pal;
        logic [15:0]       row;
        logic [HIST_W-1:0] hist;
        logic [HIST_W-1:0] adj_hist;
        logic [4:0]        disp_cnt;
        logic [3:0]        pix_idx;
        logic [2:0]        rom_cnt;
        logic [13:0]       rom_addr;
        logic              rom_en;
        logic              stall;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        ocpe_pix_t         pix;
    } ocpe_state_t;

endpackage : ocpe_pkg

// ### rtl/ocpe_top.sv
`timescale 1ns/100ps
`default_nettype none
module ocpe_top (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    output logic      [13:0]    rom_addr,
    output logic                rom_en,
    input  wire logic [15:0]    rom_data,
    output logic                core_stall,
    output ocpe_pkg::ocpe_pix_t pix
);

    ocpe_pkg::ocpe_state_t st_ff;
    ocpe_pkg::ocpe_state_t nxt_st;

    // scaling of the latched row word
    function automatic logic [15:0] scale_word(
        input logic [15:0] row_w,
        input logic        triple,
        input logic [1:0]  k
    );
        logic [5:0]  p;
        logic [5:0]  s;
        logic [15:0] w;
        w = 16'h0000;
        for (int j = 0; j < 16; j++) begin
            p = 6'(int'(k) * 16 + 15 - j);
            s = triple ? 6'(p / 6'h03) : 6'(p >> 1);
            w[j] = row_w[4'(6'h0f - s)];
        end
        return w;
    endfunction : scale_word

    // foreground colour of an attribute word
    function automatic logic [2:0] fg_of(
        input logic [15:0] a,
        input logic [15:0] p
    );
        logic [2:0] c;
        c = a[11:9];
        if (p[ocpe_pkg::P_MODE_B]) begin
            case (a[11:10])
                2'h0:    c = p[8:6];
                2'h1:    c = p[11:9];
                2'h2:    c = p[2:0];
                2'h3:    c = p[5:3];
                default: c = a[11:9];
            endcase
        end
        return c;
    endfunction : fg_of

    logic              setup;
    logic              access;
    logic              wr;
    logic              mapped;
    logic              sel3;
    logic [31:0]       rd_val;
    logic [ocpe_pkg::HIST_W-1:0] nh;
    logic [ocpe_pkg::HIST_W-1:0] na;
    logic [4:0]        dly;
    logic              on;
    logic              on_s;
    logic              neigh;
    logic              adj_on;
    logic              fr;
    logic              ul;
    logic              use_new;
    logic [2:0]        fgc;

    assign setup  = psel && !penable;
    assign access = psel && penable && st_ff.pready;
    assign wr     = access && pwrite && !st_ff.pslverr;
    // size select from upper size bit
    assign sel3   = st_ff.ctrl[ocpe_pkg::C_SIZE_SEL_B];

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            ocpe_pkg::OFS_ROW_HI: begin
                rd_val = {16'h0000, scale_word(st_ff.row, sel3, 2'h0)};
            end
            ocpe_pkg::OFS_ROW_MID: begin
                rd_val = {16'h0000, scale_word(st_ff.row, sel3, 2'h1)};
            end
            ocpe_pkg::OFS_ROW_LO: begin
                rd_val = {16'h0000, sel3 ? scale_word(st_ff.row, 1'b1, 2'h2) : st_ff.row};
            end
            ocpe_pkg::OFS_ATTR_RD: begin
                rd_val = {16'h0000, st_ff.last_ctrl, st_ff.merged};
            end
            ocpe_pkg::OFS_CTRL: begin
                rd_val = {16'h0000, st_ff.ctrl};
            end
            ocpe_pkg::OFS_PAL: begin
                rd_val = {16'h0000, st_ff.pal};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        nxt_st = st_ff;

        // apb answer one cycle after setup
        nxt_st.pready = 1'b0;
        if (setup) begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !mapped;
            nxt_st.prdata  = (mapped && !pwrite) ? rd_val : 32'h0000_0000;
        end else if (access) begin
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata  = 32'h0000_0000;
        end

        // character rom access timing
        if (st_ff.rom_cnt != 3'h0) begin
            nxt_st.rom_cnt = st_ff.rom_cnt + 3'h1;
            if (st_ff.rom_cnt == ocpe_pkg::STALL_LAST) begin
                nxt_st.row     = rom_data;
                nxt_st.rom_cnt = 3'h0;
            end
        end

        // pixel pipeline
        nh      = {st_ff.hist[ocpe_pkg::HIST_W-2:0], st_ff.disp_cur[15]};
        na      = {st_ff.adj_hist[ocpe_pkg::HIST_W-2:0], st_ff.disp_adj[15]};
        dly     = (st_ff.attr[ocpe_pkg::A_SHIFT_B] ? ocpe_pkg::SHIFT_PIX : 5'h00)
                + (st_ff.attr[ocpe_pkg::A_ITAL_B] ? {1'b0, st_ff.ctrl[11:8]} : 5'h00);
        on      = nh[dly];
        neigh   = nh[5'(dly + 5'h01)];
        adj_on  = na[dly];
        on_s    = on || (st_ff.attr[ocpe_pkg::A_SMOOTH_B] && adj_on && neigh);
        if (st_ff.attr[ocpe_pkg::A_BLINK_B] && st_ff.ctrl[ocpe_pkg::C_BLINK_B]) begin
            on_s = 1'b0;
        end
        fr      = st_ff.attr[ocpe_pkg::A_FRINGE_B] && !on_s && adj_on;
        ul      = (st_ff.attr[ocpe_pkg::A_UL1_B] && st_ff.ctrl[ocpe_pkg::C_UL1_B])
                || (st_ff.pal[ocpe_pkg::P_MODE_B] && st_ff.attr[ocpe_pkg::A_UL2_B]
                    && st_ff.ctrl[ocpe_pkg::C_UL2_B]);
        use_new = st_ff.pix_idx >= {st_ff.attr[3:2], 2'h0};
        fgc     = use_new ? fg_of(st_ff.attr, st_ff.pal) : st_ff.fg_old;

        nxt_st.pix = '0;
        if (st_ff.disp_cnt != 5'h00) begin
            nxt_st.disp_cnt   = st_ff.disp_cnt - 5'h01;
            nxt_st.pix_idx    = st_ff.pix_idx + 4'h1;
            nxt_st.hist       = nh;
            nxt_st.adj_hist   = na;
            nxt_st.disp_cur   = {st_ff.disp_cur[14:0], 1'b0};
            nxt_st.disp_adj   = {st_ff.disp_adj[14:0], 1'b0};
            nxt_st.pix.active = 1'b1;
            nxt_st.pix.fg     = on_s;
            nxt_st.pix.ul     = ul;
            nxt_st.pix.bg     = !st_ff.attr[ocpe_pkg::A_TRANS_B] && !on_s && !fr && !ul;
            if (ul) begin
                nxt_st.pix.color = st_ff.pal[14:12];
            end else if (on_s) begin
                nxt_st.pix.color = fgc;
            end else if (fr) begin
                nxt_st.pix.color = ocpe_pkg::COL_BLACK;
            end else if (!st_ff.attr[ocpe_pkg::A_TRANS_B]) begin
                nxt_st.pix.color = st_ff.attr[14:12];
            end
        end

        if (wr) begin
            case (paddr)
                ocpe_pkg::OFS_ROW_HI: begin
                    nxt_st.cur_shift = pwdata[15:0];
                end
                ocpe_pkg::OFS_ROW_MID: begin
                    nxt_st.adj_shift = pwdata[15:0];
                end
                ocpe_pkg::OFS_ROW_LO: begin
                    nxt_st.attr      = pwdata[15:0];
                    nxt_st.fg_old    = fg_of(st_ff.attr, st_ff.pal);
                    nxt_st.disp_cnt  = ocpe_pkg::PERIOD_CYC;
                    nxt_st.pix_idx   = 4'h0;
                    nxt_st.disp_cur  = st_ff.cur_shift;
                    nxt_st.disp_adj  = st_ff.adj_shift;
                    nxt_st.cur_shift = ocpe_pkg::RST_WORD;
                    nxt_st.adj_shift = ocpe_pkg::RST_WORD;
                end
                ocpe_pkg::OFS_ATTR_RD: begin
                    nxt_st.last_ctrl = pwdata[ocpe_pkg::A_CTRL_B];
                    if (pwdata[ocpe_pkg::A_CTRL_B]) begin
                        nxt_st.merged[8:0] = pwdata[8:0];
                        nxt_st.rom_addr    = {9'h000, st_ff.ctrl[4:0]};
                    end else begin
                        nxt_st.merged[14:9] = pwdata[14:9];
                        nxt_st.rom_addr     = {pwdata[8:0], st_ff.ctrl[4:0]};
                    end
                    nxt_st.rom_cnt = 3'h1;
                end
                ocpe_pkg::OFS_CTRL: begin
                    nxt_st.ctrl = pwdata[15:0];
                end
                ocpe_pkg::OFS_PAL: begin
                    nxt_st.pal = pwdata[15:0];
                end
                default: begin
                    nxt_st.pal = st_ff.pal;
                end
            endcase
        end

        nxt_st.rom_en = nxt_st.rom_cnt != 3'h0;
        nxt_st.stall  = (nxt_st.rom_cnt >= ocpe_pkg::STALL_START)
                     && (nxt_st.rom_cnt <= ocpe_pkg::STALL_LAST);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata     = st_ff.prdata;
    assign pready     = st_ff.pready;
    assign pslverr    = st_ff.pslverr;
    assign rom_addr   = st_ff.rom_addr;
    assign rom_en     = st_ff.rom_en;
    assign core_stall = st_ff.stall;
    assign pix        = st_ff.pix;

endmodule : ocpe_top
`default_nettype wire

// ### verif/ocpe_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ocpe_top_asserts (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [13:0]         rom_addr,
    input wire logic                rom_en,
    input wire logic [15:0]         rom_data,
    input wire logic                core_stall,
    input wire ocpe_pkg::ocpe_pix_t pix
);
    logic [4:0] run_ff;
    logic       wr_attr;
    logic       wr_code;
    logic       mapped;
    assign wr_attr = psel && penable && pwrite && (paddr == ocpe_pkg::OFS_ROW_LO);
    assign wr_code = psel && penable && pwrite && (paddr == ocpe_pkg::OFS_ATTR_RD);
    assign mapped  = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    // length of the current active pixel run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= 5'h00;
        end else if (!pix.active) begin
            run_ff <= 5'h00;
        end else if (run_ff != 5'h1f) begin
            run_ff <= run_ff + 5'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read data not zero");
    a_fetch_cause: assert property ($rose(rom_en) |-> $past(wr_code))
        else $error("fetch without code write");
    a_stall_window: assert property ($rose(rom_en) |->
        !core_stall [*3] ##1 core_stall [*3] ##1 !core_stall)
        else $error("stall window wrong");
    a_disp_start: assert property (wr_attr && pready |-> ##[1:2] pix.active)
        else $error("display not started");
    a_disp_cause: assert property ($rose(pix.active) |-> $past(wr_attr) || $past(wr_attr, 2))
        else $error("display without attribute write");
    a_disp_length: assert property ($fell(pix.active) |-> run_ff == 5'h10)
        else $error("display run not 16 cycles");
    cover property ($rose(core_stall));
    cover property (pready && pslverr);
    cover property ($fell(pix.active));
endmodule : ocpe_top_asserts
`default_nettype wire

// ### verif/ocpe_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ocpe_top_tb;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, rom_en;
    logic                core_stall, e;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, q;
    logic [13:0]         rom_addr;
    logic [15:0]         rom_data;
    logic [2:0]          fgc, bgc;
    ocpe_pkg::ocpe_pix_t pix;
    int                  failures, n_checks, cycles, n_act, n_fg, n_bg, n_col, s;
    logic [15:0]         cur_t [6] = '{16'h0, 16'h0, 16'hffff, 16'h0, 16'hffff, 16'h0};
    logic [15:0]         adj_t [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hffff};
    logic [15:0]         attr_t [6] = '{16'h5000, 16'h5040, 16'h0400, 16'h0480, 16'h0804,
                                        16'h1002};
    int                  ef [6] = '{0, 0, 16, 8, 16, 0};
    int                  eb [6] = '{16, 0, 0, 8, 0, 0};
    int                  ec [6] = '{0, 0, 16, 8, 12, 0};

    ocpe_top i_ocpe_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_addr(rom_addr), .rom_en(rom_en), .rom_data(rom_data),
        .core_stall(core_stall), .pix(pix));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic conclude;
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk

    // one apb transfer, released after the answer
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : acc

    function automatic logic [15:0] scale(input logic [15:0] r, input int f, input int k);
        logic [15:0] o;
        for (int j = 0; j < 16; j++) o[j] = r[15 - (16 * k + 15 - j) / f];
        return o;
    endfunction : scale

    // pixel statistics and timeout
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            conclude();
        end
        if (pix.active === 1'b1) begin
            n_act++;
            if (pix.fg === 1'b1) n_fg++;
            if (pix.bg === 1'b1) n_bg++;
            if (pix.fg === 1'b1 && pix.color === fgc) n_col++;
            if (pix.bg === 1'b1) chk("bg colour", {29'h0, bgc}, {29'h0, pix.color});
        end
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rom_data = 16'hb38d;
        {fgc, bgc} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 3; i < 6; i++) begin
            acc(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, q);
        end
        acc(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        acc(1'b1, 8'h1c, 32'h0000ffff);
        chk("unmapped wr err", 32'h1, {31'h0, e});
        n_act = 0;
        acc(1'b1, ocpe_pkg::OFS_ROW_HI, 32'h0000ffff);
        repeat (24) @(posedge pclk);
        chk("active without attr", 32'h0, n_act);
        acc(1'b1, ocpe_pkg::OFS_ROW_HI, 32'h0);
        acc(1'b1, ocpe_pkg::OFS_ATTR_RD, 32'h00000005);
        chk("rom addr", 32'h000000a0, {18'h0, rom_addr});
        chk("rom enable", 32'h1, {31'h0, rom_en});
        repeat (8) @(posedge pclk);
        for (s = 0; s < 2; s++) begin
            acc(1'b1, ocpe_pkg::OFS_CTRL, (s == 1) ? 32'h40 : 32'h0);
            for (int k = 0; k < 3; k++) begin
                acc(1'b0, 8'(4 * k), 32'h0);
                chk("scaled row", {16'h0, (s == 0 && k == 2) ? scale(16'hb38d, 1, 0)
                    : scale(16'hb38d, (s == 1) ? 3 : 2, k)}, q);
            end
        end
        acc(1'b0, ocpe_pkg::OFS_CTRL, 32'h0);
        chk("ctrl readback", 32'h40, q);
        acc(1'b1, ocpe_pkg::OFS_CTRL, 32'h0);
        acc(1'b1, ocpe_pkg::OFS_ATTR_RD, 32'h00008123);
        repeat (8) @(posedge pclk);
        acc(1'b0, ocpe_pkg::OFS_ATTR_RD, 32'h0);
        chk("merge control", 32'h00008123, q);
        acc(1'b1, ocpe_pkg::OFS_ATTR_RD, 32'h00005a05);
        repeat (8) @(posedge pclk);
        acc(1'b0, ocpe_pkg::OFS_ATTR_RD, 32'h0);
        chk("merge displayed", 32'h00005b23, q);
        for (int i = 0; i < 6; i++) begin
            fgc = attr_t[i][11:9];
            bgc = attr_t[i][14:12];
            {n_act, n_fg, n_bg, n_col} = '0;
            // attributes eight cycles after current line
            if (cur_t[i] != 16'h0) acc(1'b1, ocpe_pkg::OFS_ROW_HI, {16'h0, cur_t[i]});
            else @(posedge pclk);
            if (adj_t[i] != 16'h0) acc(1'b1, ocpe_pkg::OFS_ROW_MID, {16'h0, adj_t[i]});
            else repeat (3) @(posedge pclk);
            repeat (2) @(posedge pclk);
            acc(1'b1, ocpe_pkg::OFS_ROW_LO, {16'h0, attr_t[i]});
            repeat (20) @(posedge pclk);
            chk("active count", 32'd16, n_act);
            chk("fg count", ef[i], n_fg);
            chk("bg count", eb[i], n_bg);
            chk("fg colour count", ec[i], n_col);
        end
        conclude();
    end
endmodule : ocpe_top_tb

bind ocpe_top ocpe_top_asserts i_ocpe_top_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
    .rom_en(rom_en), .rom_data(rom_data), .core_stall(core_stall), .pix(pix));
`default_nettype wire
